// >>> pse_consts.svh
// Function
// - Set limit-timeout flag after limit time exceeded
// - Set start-fault flag on turn-on faults
// - Update both flag kinds per channel independently
// - Start fault with enable-change means inrush fault
// - Otherwise log cause to power-on fault register
// - Auto mode ignores invalid discovery start faults
// - Host may repower a single dual-signature channel
// - Low class single signature: staggered channel turn-on
// - Low class fault: both off, cool-down, flags
// - High class single signature: parallel inrush, power-good
// - High class fault: both off, cool-down, flags
// - Dual signature channels run inrush independently
// - View command plain, clear command clears register
// - Clear-on-read releases the interrupt request
// - Any set bit feeds summary interrupt
// - Thermal shutdown sets flag, turns channels off
// - Below low threshold channels may restart
// - Logic supply lockout sets bit six
// - Preserved bits survive the reset pin
// - Fast shutdown disabling channels sets bit one
`ifndef PSE_CONSTS_SVH
`define PSE_CONSTS_SVH

// ----------------------------------------------------------------
// Commands
// ----------------------------------------------------------------
`define PSE_CMD_START_VIEW   8'h08
`define PSE_CMD_START_CLEAR  8'h09
`define PSE_CMD_SFE_VIEW     8'h0a
`define PSE_CMD_SFE_CLEAR    8'h0b

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PSE_START_LIM_LSB    4
`define PSE_START_FAULT_LSB  0
`define PSE_SFE_THERMAL      7
`define PSE_SFE_LOGIC_UV     6
`define PSE_SFE_WARN         5
`define PSE_SFE_MAIN_UV      4
`define PSE_SFE_OVL34        3
`define PSE_SFE_OVL12        2
`define PSE_SFE_FAST_SD      1
`define PSE_SFE_MEM          0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PSE_START_RST        8'h00
`define PSE_SFE_POR_HI       4'h7
`define PSE_SFE_RST_LO       4'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PSE_CLK_PERIOD_NS    50
`define PSE_LIMIT_TIME_US    64
`define PSE_LIMIT_CYCLES     ((`PSE_LIMIT_TIME_US * 1000 + `PSE_CLK_PERIOD_NS - 1) / `PSE_CLK_PERIOD_NS)
`define PSE_COOL_TIME_MS     1000
`define PSE_COOL_CYCLES      ((`PSE_COOL_TIME_MS * 1000000) / `PSE_CLK_PERIOD_NS)

`endif

// >>> pse_pkg.sv
`default_nettype none

package pse_pkg;

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_INRUSH,
		SEQ_POWERED,
		SEQ_COOL
	} pse_seq_state_t;

	typedef logic [24:0] pse_cool_cnt_t;
	typedef logic [15:0] pse_lim_cnt_t;

endpackage : pse_pkg
`default_nettype wire

// >>> pse_port_seq.sv
`timescale 1ns/10ps
`default_nettype none
`include "pse_consts.svh"

module pse_port_seq #(
	parameter int unsigned COOL_CYCLES = `PSE_COOL_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       single_sig,
	input  wire logic       high_class,
	input  wire logic       port_req,
	input  wire logic [1:0] channel_power_on_command,
	input  wire logic [1:0] inrush_end,
	input  wire logic [1:0] inrush_bad,
	input  wire logic       force_off,
	output logic      [1:0] ch_en,
	output logic      [1:0] pg,
	output logic      [1:0] fault_ev,
	output logic            cooling
);

	pse_pkg::pse_seq_state_t st_r, st_nxt;
	pse_pkg::pse_cool_cnt_t  cnt_r, cnt_nxt;
	logic [1:0]              en_r, en_nxt, pg_r, pg_nxt, ev_r, ev_nxt, done_r, done_nxt;

	// ----------------------------------------------------------------
	// Port sequencing
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt   = st_r;
		cnt_nxt  = cnt_r;
		en_nxt   = en_r;
		pg_nxt   = pg_r;
		ev_nxt   = 2'h0;
		done_nxt = done_r;
		case (st_r)
			pse_pkg::SEQ_IDLE: begin
				done_nxt = 2'h0;
				if (single_sig) begin
					en_nxt = 2'h0;
					pg_nxt = 2'h0;
					if (port_req && !force_off) begin
						st_nxt = pse_pkg::SEQ_INRUSH;
						en_nxt = high_class ? 2'h3 : 2'h1;
					end
				end else begin
					// Each channel stands alone; a fault never touches the partner
					for (int i = 0; i < 2; i++) begin
						if (force_off) begin
							en_nxt[i] = 1'b0;
							pg_nxt[i] = 1'b0;
						end else if (channel_power_on_command[i] && !en_r[i]) begin
							en_nxt[i] = 1'b1;
							pg_nxt[i] = 1'b0;
						end else if (en_r[i] && !pg_r[i] && inrush_end[i]) begin
							if (inrush_bad[i]) begin
								en_nxt[i] = 1'b0;
								ev_nxt[i] = 1'b1;
							end else begin
								pg_nxt[i] = 1'b1;
							end
						end
					end
				end
			end
			pse_pkg::SEQ_INRUSH: begin
				if (force_off) begin
					st_nxt = pse_pkg::SEQ_IDLE;
					en_nxt = 2'h0;
				end else if (high_class) begin
					done_nxt = done_r | inrush_end;
					if (|(inrush_end & inrush_bad)) begin
						st_nxt  = pse_pkg::SEQ_COOL;
						en_nxt  = 2'h0;
						ev_nxt  = 2'h3;
						cnt_nxt = '0;
					end else if (&(done_r | inrush_end)) begin
						st_nxt = pse_pkg::SEQ_POWERED;
						pg_nxt = 2'h3;
					end
				end else if (inrush_end[0]) begin
					if (inrush_bad[0]) begin
						st_nxt  = pse_pkg::SEQ_COOL;
						en_nxt  = 2'h0;
						ev_nxt  = 2'h3;
						cnt_nxt = '0;
					end else begin
						st_nxt = pse_pkg::SEQ_POWERED;
						en_nxt = 2'h3;
						pg_nxt = 2'h3;
					end
				end
			end
			pse_pkg::SEQ_POWERED: begin
				if (force_off || !port_req) begin
					st_nxt = pse_pkg::SEQ_IDLE;
					en_nxt = 2'h0;
					pg_nxt = 2'h0;
				end
			end
			default: begin
				cnt_nxt = cnt_r + 25'h1;
				if (cnt_r == 25'(COOL_CYCLES - 1))
					st_nxt = pse_pkg::SEQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_r   <= pse_pkg::SEQ_IDLE;
			cnt_r  <= '0;
			en_r   <= 2'h0;
			pg_r   <= 2'h0;
			ev_r   <= 2'h0;
			done_r <= 2'h0;
		end else begin
			st_r   <= st_nxt;
			cnt_r  <= cnt_nxt;
			en_r   <= en_nxt;
			pg_r   <= pg_nxt;
			ev_r   <= ev_nxt;
			done_r <= done_nxt;
		end
	end

	assign ch_en    = en_r;
	assign pg       = pg_r;
	assign fault_ev = ev_r;
	assign cooling  = (st_r == pse_pkg::SEQ_COOL);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	low_class_stagger_a: assert property (@(posedge clk) disable iff (!resetn)
		st_r == pse_pkg::SEQ_INRUSH && !high_class |-> en_r == 2'h1)
		else $error("low class inrush must run on one channel");

	ss_fault_both_a: assert property (@(posedge clk) disable iff (!resetn)
		st_r == pse_pkg::SEQ_INRUSH && !force_off && high_class && |(inrush_end & inrush_bad)
		|=> ev_r == 2'h3 && en_r == 2'h0 && cooling)
		else $error("single signature fault must stop both channels");

	cool_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		$rose(cooling) |-> cooling [*8])
		else $error("cool-down ended too early");

	cover_powered_c: cover property (@(posedge clk) disable iff (!resetn)
		st_r == pse_pkg::SEQ_INRUSH ##1 st_r == pse_pkg::SEQ_POWERED);

endmodule : pse_port_seq
`default_nettype wire

// >>> pse_event_flags.sv
`timescale 1ns/10ps
`default_nettype none
`include "pse_consts.svh"

module pse_event_flags #(
	parameter int unsigned COOL_CYCLES = `PSE_COOL_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       por_n,
	input  wire logic       reg_rd_en,
	input  wire logic [7:0] reg_cmd,
	output logic      [7:0] reg_rd_data,
	output logic            reg_rd_valid,
	input  wire logic       auto_mode,
	input  wire logic [1:0] single_sig,
	input  wire logic [1:0] high_class,
	input  wire logic [1:0] port_req,
	input  wire logic [3:0] channel_power_on_command,
	input  wire logic [3:0] inrush_end,
	input  wire logic [3:0] inrush_bad,
	input  wire logic [3:0] class_det_error,
	input  wire logic [3:0] power_enable_change_flag,
	input  wire logic [3:0] shutdown_code_disable,
	input  wire logic [1:0] summed_overload_ev,
	input  wire logic       program_memory_fault_ev,
	input  wire logic [3:0] at_limit_pin,
	input  wire logic       temp_high_pin,
	input  wire logic       temp_below_low_pin,
	input  wire logic       logic_uvlo_pin,
	input  wire logic       logic_warn_pin,
	input  wire logic       main_uv_pin,
	input  wire logic       fast_shutdown_pin,
	output logic      [3:0] ch_en,
	output logic      [3:0] power_good_flags,
	output logic      [3:0] inrush_fault_ev,
	output logic      [3:0] pon_fault_log,
	output logic      [1:0] port_cooling,
	output logic            start_event_pending,
	output logic            supply_event_pending,
	output logic            thermal_block
);

	localparam int unsigned LIM_CYC = `PSE_LIMIT_CYCLES;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [9:0] pin_meta_r, pin_sync_r;
	logic [3:0] at_limit_s;
	logic       temp_high_s, temp_low_s, logic_uvlo_s, logic_warn_s, main_uv_s, fast_sd_s;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pin_meta_r <= 10'h000;
			pin_sync_r <= 10'h000;
		end else begin
			pin_meta_r <= {at_limit_pin, temp_high_pin, temp_below_low_pin, logic_uvlo_pin,
			               logic_warn_pin, main_uv_pin, fast_shutdown_pin};
			pin_sync_r <= pin_meta_r;
		end
	end

	assign {at_limit_s, temp_high_s, temp_low_s, logic_uvlo_s, logic_warn_s, main_uv_s, fast_sd_s} = pin_sync_r;

	// ----------------------------------------------------------------
	// Read decode
	// ----------------------------------------------------------------
	function automatic logic [1:0] pse_cmd_sel(input logic [7:0] cmd);
		// [1] supply register, [0] clear-on-read view
		if (cmd == `PSE_CMD_START_VIEW)
			pse_cmd_sel = 2'b00;
		else if (cmd == `PSE_CMD_START_CLEAR)
			pse_cmd_sel = 2'b01;
		else if (cmd == `PSE_CMD_SFE_VIEW)
			pse_cmd_sel = 2'b10;
		else if (cmd == `PSE_CMD_SFE_CLEAR)
			pse_cmd_sel = 2'b11;
		else
			pse_cmd_sel = 2'b00;
	endfunction : pse_cmd_sel

	function automatic logic pse_cmd_hit(input logic [7:0] cmd);
		pse_cmd_hit = (cmd[7:2] == 6'h02);
	endfunction : pse_cmd_hit

	logic [1:0] sel;
	logic       rd_start_clr, rd_sfe_clr;

	assign sel          = pse_cmd_sel(reg_cmd);
	assign rd_start_clr = reg_rd_en && pse_cmd_hit(reg_cmd) && sel == 2'b01;
	assign rd_sfe_clr   = reg_rd_en && pse_cmd_hit(reg_cmd) && sel == 2'b11;

	// ----------------------------------------------------------------
	// Limit timers
	// ----------------------------------------------------------------
	logic [3:0] lim_hit;

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_lim
			pse_pkg::pse_lim_cnt_t cnt_r, cnt_nxt;

			// Saturates at the threshold so one excursion flags once
			always_comb begin
				if (!at_limit_s[g])
					cnt_nxt = '0;
				else if (cnt_r != 16'(LIM_CYC))
					cnt_nxt = cnt_r + 16'h1;
				else
					cnt_nxt = cnt_r;
			end

			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn)
					cnt_r <= '0;
				else
					cnt_r <= cnt_nxt;
			end

			assign lim_hit[g] = at_limit_s[g] && cnt_r == 16'(LIM_CYC - 1);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Thermal block and port sequencers
	// ----------------------------------------------------------------
	logic       blk_r, blk_nxt;
	logic [3:0] ch_en_prev_r;
	wire  [3:0] seq_fault, seq_en, seq_pg;
	wire  [1:0] seq_cool;

	always_comb begin
		if (temp_high_s)
			blk_nxt = 1'b1;
		else if (temp_low_s)
			blk_nxt = 1'b0;
		else
			blk_nxt = blk_r;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			blk_r        <= 1'b0;
			ch_en_prev_r <= 4'h0;
		end else begin
			blk_r        <= blk_nxt;
			ch_en_prev_r <= ch_en;
		end
	end

	assign thermal_block    = blk_r;
	assign ch_en            = seq_en;
	assign power_good_flags = seq_pg;
	assign port_cooling     = seq_cool;

	generate
		for (g = 0; g < 2; g++) begin : g_port
			pse_port_seq #(
				.COOL_CYCLES (COOL_CYCLES)
			) u_seq (
				.clk                      (clk),
				.resetn                   (resetn),
				.single_sig               (single_sig[g]),
				.high_class               (high_class[g]),
				.port_req                 (port_req[g]),
				.channel_power_on_command (channel_power_on_command[2*g+1:2*g]),
				.inrush_end               (inrush_end[2*g+1:2*g]),
				.inrush_bad               (inrush_bad[2*g+1:2*g]),
				.force_off                (blk_r),
				.ch_en                    (seq_en[2*g+1:2*g]),
				.pg                       (seq_pg[2*g+1:2*g]),
				.fault_ev                 (seq_fault[2*g+1:2*g]),
				.cooling                  (seq_cool[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Start and limit flags
	// ----------------------------------------------------------------
	logic [3:0] st_set, ch_off;
	logic [7:0] start_r, start_nxt, start_clr;
	logic [3:0] inrush_r, inrush_nxt, ponlog_r, ponlog_nxt;

	assign ch_off = ch_en_prev_r & ~ch_en;

	always_comb begin
		st_set     = seq_fault | (auto_mode ? 4'h0 : class_det_error);
		start_clr  = (rd_start_clr ? start_r : 8'h00) | {ch_off, ch_off};
		// Set wins over any clear landing in the same cycle
		start_nxt  = (start_r & ~start_clr) | {lim_hit, st_set};
		inrush_nxt = st_set & power_enable_change_flag;
		ponlog_nxt = st_set & ~power_enable_change_flag;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			start_r  <= `PSE_START_RST;
			inrush_r <= 4'h0;
			ponlog_r <= 4'h0;
		end else begin
			start_r  <= start_nxt;
			inrush_r <= inrush_nxt;
			ponlog_r <= ponlog_nxt;
		end
	end

	assign inrush_fault_ev = inrush_r;
	assign pon_fault_log   = ponlog_r;

	// ----------------------------------------------------------------
	// Supply_fault_event_clear flags
	// ----------------------------------------------------------------
	logic [7:0] sfe_r, sfe_set, sfe_clr, sfe_nxt;
	logic [3:0] sfe_hi_r, sfe_lo_r;
	logic       fast_sd_set;

	always_comb begin
		fast_sd_set = (fast_sd_s && |ch_en) || |(shutdown_code_disable & ch_en);
		sfe_set  = {temp_high_s, logic_uvlo_s, logic_warn_s, main_uv_s,
		            summed_overload_ev[1], summed_overload_ev[0], fast_sd_set, program_memory_fault_ev};
		sfe_clr  = rd_sfe_clr ? sfe_r : 8'h00;
		// Lockout flag cannot be cleared while the main supply is still low
		if (main_uv_s)
			sfe_clr[`PSE_SFE_LOGIC_UV] = 1'b0;
		sfe_nxt  = (sfe_r & ~sfe_clr) | sfe_set;
	end

	// Upper bits only return to their power-up value on power-on reset
	always_ff @(posedge clk or negedge por_n) begin
		if (!por_n)
			sfe_hi_r <= `PSE_SFE_POR_HI;
		else
			sfe_hi_r <= sfe_nxt[7:4];
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			sfe_lo_r <= `PSE_SFE_RST_LO;
		else
			sfe_lo_r <= sfe_nxt[3:0];
	end

	assign sfe_r                = {sfe_hi_r, sfe_lo_r};
	assign start_event_pending  = |start_r;
	assign supply_event_pending = |sfe_r;

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	logic [7:0] rd_data_r, rd_data_nxt;
	logic       rd_valid_r;

	always_comb begin
		if (!pse_cmd_hit(reg_cmd))
			rd_data_nxt = 8'h00;
		else if (sel[1])
			rd_data_nxt = sfe_r;
		else
			rd_data_nxt = start_r;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_data_r  <= 8'h00;
			rd_valid_r <= 1'b0;
		end else begin
			rd_data_r  <= reg_rd_en ? rd_data_nxt : rd_data_r;
			rd_valid_r <= reg_rd_en;
		end
	end

	assign reg_rd_data  = rd_data_r;
	assign reg_rd_valid = rd_valid_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn || !por_n);

	view_no_clear_a: assert property (
		reg_rd_en && reg_cmd == `PSE_CMD_SFE_VIEW |=> (sfe_r & $past(sfe_r)) == $past(sfe_r)
		&& reg_rd_data == $past(sfe_r))
		else $error("view read changed supply flags");

	clear_read_a: assert property (
		reg_rd_en && reg_cmd == `PSE_CMD_SFE_CLEAR && sfe_set == 8'h00 && !main_uv_s
		|=> sfe_r == 8'h00 && !supply_event_pending)
		else $error("clear read left supply flags set");

	set_wins_a: assert property (
		|sfe_set |=> (sfe_r & $past(sfe_set)) == $past(sfe_set))
		else $error("supply event lost against clear");

	limit_flag_a: assert property (
		|lim_hit |=> (start_r[7:4] & $past(lim_hit)) == $past(lim_hit))
		else $error("limit timeout not flagged");

	inrush_split_a: assert property (
		|st_set |=> inrush_fault_ev == $past(st_set & power_enable_change_flag)
		&& pon_fault_log == $past(st_set & ~power_enable_change_flag))
		else $error("start fault routed wrong");

	auto_mask_a: assert property (
		auto_mode && seq_fault == 4'h0 |=> (start_r[3:0] & ~$past(start_r[3:0])) == 4'h0)
		else $error("discovery error flagged in auto mode");

	thermal_off_a: assert property (
		temp_high_s |-> ##[1:3] ch_en == 4'h0)
		else $error("channels not off on thermal shutdown");

	lockout_bit_a: assert property (
		logic_uvlo_s |=> sfe_r[`PSE_SFE_LOGIC_UV])
		else $error("logic supply lockout not flagged");

	fast_sd_a: assert property (
		fast_sd_set |=> sfe_r[`PSE_SFE_FAST_SD])
		else $error("fast shutdown not flagged");

	cover_clear_c: cover property (reg_rd_en && reg_cmd == `PSE_CMD_SFE_CLEAR && supply_event_pending);
	cover_limit_c: cover property (|lim_hit);
	cover_thermal_c: cover property (blk_r ##1 !blk_r);

endmodule : pse_event_flags
`default_nettype wire

// >>> pse_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Host side of the command-addressed register port
// ----------------------------------------------------------------
module pse_host_model (
	input  wire logic       clk,
	input  wire logic [7:0] reg_rd_data,
	input  wire logic       reg_rd_valid,
	output logic            reg_rd_en,
	output logic      [7:0] reg_cmd
);
	initial begin
		reg_rd_en = 1'b0;
		reg_cmd   = 8'h00;
	end

	// One request per call; the answer is taken at the edge after the taking edge
	task automatic read(input logic [7:0] cmd, output logic [7:0] data, output logic valid);
		@(posedge clk);
		reg_rd_en <= 1'b1;
		reg_cmd   <= cmd;
		@(posedge clk);
		reg_rd_en <= 1'b0;
		// A released command never keeps showing the last code
		reg_cmd   <= ~cmd;
		@(posedge clk);
		data  = reg_rd_data;
		valid = reg_rd_valid;
	endtask : read
endmodule : pse_host_model

`default_nettype wire

// >>> tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
	logic       clk = 1'b0;
	logic       resetn = 1'b0;
	logic       por_n = 1'b0;
	logic       reg_rd_en;
	logic [7:0] reg_cmd;
	logic [7:0] reg_rd_data;
	logic       reg_rd_valid;
	logic       auto_mode = 1'b0;
	logic [1:0] single_sig = 2'h0;
	logic [1:0] high_class = 2'h0;
	logic [1:0] port_req = 2'h0;
	logic [3:0] channel_power_on_command = 4'h0;
	logic [3:0] shutdown_code_disable = 4'h0;
	logic [3:0] inrush_end = 4'h0;
	logic [3:0] inrush_bad = 4'h0;
	logic [3:0] class_det_error = 4'h0;
	logic [3:0] power_enable_change_flag = 4'h0;
	logic [1:0] summed_overload_ev = 2'h0;
	logic       program_memory_fault_ev = 1'b0;
	logic [3:0] at_limit_pin = 4'h0;
	logic       temp_high_pin = 1'b0;
	logic       temp_below_low_pin = 1'b0;
	logic       logic_uvlo_pin = 1'b0;
	logic       logic_warn_pin = 1'b0;
	logic       main_uv_pin = 1'b0;
	logic       fast_shutdown_pin = 1'b0;
	logic [3:0] ch_en;
	logic [3:0] power_good_flags;
	logic [3:0] inrush_fault_ev;
	logic [3:0] pon_fault_log;
	logic [1:0] port_cooling;
	logic       start_event_pending;
	logic       supply_event_pending;
	logic       thermal_block;
	logic [3:0] pon_seen = 4'h0;
	logic [3:0] ifault_seen = 4'h0;
	logic [7:0] rd_d;
	logic       rd_v;
	int         mismatches = 0;
	int         samples_checked = 0;
	int         cycles = 0;

	always #25 clk = ~clk;

	pse_host_model host (.clk(clk), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
		.reg_rd_en(reg_rd_en), .reg_cmd(reg_cmd));

	// Short cool-down keeps the run brief; expectations follow this value
	pse_event_flags #(.COOL_CYCLES(16)) DUT (
		.clk(clk), .resetn(resetn), .por_n(por_n), .reg_rd_en(reg_rd_en), .reg_cmd(reg_cmd),
		.reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .auto_mode(auto_mode),
		.single_sig(single_sig), .high_class(high_class), .port_req(port_req),
		.channel_power_on_command(channel_power_on_command),
		.inrush_end(inrush_end), .inrush_bad(inrush_bad), .class_det_error(class_det_error),
		.power_enable_change_flag(power_enable_change_flag), .shutdown_code_disable(shutdown_code_disable),
		.summed_overload_ev(summed_overload_ev), .program_memory_fault_ev(program_memory_fault_ev),
		.at_limit_pin(at_limit_pin), .temp_high_pin(temp_high_pin), .temp_below_low_pin(temp_below_low_pin),
		.logic_uvlo_pin(logic_uvlo_pin), .logic_warn_pin(logic_warn_pin), .main_uv_pin(main_uv_pin),
		.fast_shutdown_pin(fast_shutdown_pin), .ch_en(ch_en), .power_good_flags(power_good_flags),
		.inrush_fault_ev(inrush_fault_ev), .pon_fault_log(pon_fault_log), .port_cooling(port_cooling),
		.start_event_pending(start_event_pending), .supply_event_pending(supply_event_pending),
		.thermal_block(thermal_block));

	// ----------------------------------------------------------------
	// Sticky capture of one-cycle strobes
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (!resetn) begin
			pon_seen <= 4'h0;
			ifault_seen <= 4'h0;
		end else begin
			pon_seen <= pon_seen | pon_fault_log;
			ifault_seen <= ifault_seen | inrush_fault_ev;
		end
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			mismatches++;
			print_verdict();
		end
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic print_verdict();
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : print_verdict

	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	task automatic rd_chk(input logic [7:0] cmd, input logic [7:0] mask, input logic [7:0] exp, input string nm);
		host.read(cmd, rd_d, rd_v);
		check({nm, "_valid"}, {7'h00, rd_v}, 8'h01);
		check(nm, rd_d & mask, exp);
	endtask : rd_chk

	// Por also restores the preserved supply bits
	task automatic rst(input logic por);
		resetn <= 1'b0;
		if (por) begin
			por_n <= 1'b0;
		end
		single_sig <= 2'h0;
		high_class <= 2'h0;
		inrush_bad <= 4'h0;
		power_enable_change_flag <= 4'h0;
		temp_below_low_pin <= 1'b0;
		tick(10);
		resetn <= 1'b1;
		por_n <= 1'b1;
		tick(3);
	endtask : rst

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rst(1'b1);
		check("pending_por", {7'h00, supply_event_pending}, 8'h01);
		rd_chk(8'h0a, 8'hff, 8'h70, "supply_por");
		rd_chk(8'h0b, 8'hff, 8'h70, "supply_clear");
		rd_chk(8'h0a, 8'hff, 8'h00, "supply_cleared");
		check("pending_clr", {7'h00, supply_event_pending}, 8'h00);
		rd_chk(8'h0c, 8'hff, 8'h00, "unmapped");
		summed_overload_ev <= 2'h3;
		program_memory_fault_ev <= 1'b1;
		logic_uvlo_pin <= 1'b1;
		logic_warn_pin <= 1'b1;
		main_uv_pin <= 1'b1;
		tick(1);
		summed_overload_ev <= 2'h0;
		program_memory_fault_ev <= 1'b0;
		tick(4);
		logic_uvlo_pin <= 1'b0;
		logic_warn_pin <= 1'b0;
		main_uv_pin <= 1'b0;
		tick(4);
		rd_chk(8'h0a, 8'hff, 8'h7d, "supply_events");
		rst(1'b0);
		rd_chk(8'h0a, 8'hff, 8'h70, "supply_pin_rst");
		// Event arriving in the same cycle as the clearing read
		fork
			host.read(8'h0b, rd_d, rd_v);
			begin
				tick(1);
				program_memory_fault_ev <= 1'b1;
				tick(1);
				program_memory_fault_ev <= 1'b0;
			end
		join
		check("race_read", rd_d, 8'h70);
		rd_chk(8'h0a, 8'hff, 8'h01, "supply_race");
		rst(1'b0);
		single_sig <= 2'h1;
		port_req <= 2'h1;
		tick(4);
		check("low_primary", {4'h0, ch_en}, 8'h01);
		inrush_end <= 4'h1;
		tick(1);
		inrush_end <= 4'h0;
		tick(3);
		check("low_both", {4'h0, ch_en}, 8'h03);
		check("low_pg", {4'h0, power_good_flags}, 8'h03);
		fast_shutdown_pin <= 1'b1;
		tick(6);
		rd_chk(8'h0a, 8'h02, 8'h02, "fast_sd");
		fast_shutdown_pin <= 1'b0;
		port_req <= 2'h0;
		rst(1'b0);
		single_sig <= 2'h2;
		port_req <= 2'h2;
		tick(4);
		check("low1_primary", {4'h0, ch_en}, 8'h04);
		inrush_bad <= 4'h4;
		inrush_end <= 4'h4;
		tick(1);
		inrush_end <= 4'h0;
		port_req <= 2'h0;
		tick(3);
		check("low1_off", {4'h0, ch_en}, 8'h00);
		check("low1_cool", {6'h00, port_cooling}, 8'h02);
		rd_chk(8'h08, 8'hff, 8'h0c, "low1_start");
		check("low1_pon", {7'h00, pon_seen[2]}, 8'h01);
		tick(20);
		check("low1_cool_end", {6'h00, port_cooling}, 8'h00);
		rst(1'b0);
		single_sig <= 2'h1;
		high_class <= 2'h1;
		port_req <= 2'h1;
		power_enable_change_flag <= 4'h3;
		tick(4);
		check("high_both", {4'h0, ch_en}, 8'h03);
		inrush_bad <= 4'h2;
		inrush_end <= 4'h3;
		tick(1);
		inrush_end <= 4'h0;
		port_req <= 2'h0;
		tick(3);
		check("high_off", {4'h0, ch_en}, 8'h00);
		rd_chk(8'h08, 8'hff, 8'h03, "high_start");
		check("high_inrush", {7'h00, ifault_seen[1]}, 8'h01);
		check("high_no_pon", {7'h00, pon_seen[1]}, 8'h00);
		rst(1'b0);
		channel_power_on_command <= 4'hc;
		tick(1);
		channel_power_on_command <= 4'h0;
		tick(3);
		check("dual_on", {4'h0, ch_en}, 8'h0c);
		inrush_bad <= 4'h4;
		inrush_end <= 4'hc;
		tick(1);
		inrush_end <= 4'h0;
		tick(3);
		check("dual_one_off", {4'h0, ch_en}, 8'h08);
		check("dual_pg", {4'h0, power_good_flags}, 8'h08);
		rd_chk(8'h08, 8'hff, 8'h04, "dual_start");
		inrush_bad <= 4'h0;
		channel_power_on_command <= 4'h4;
		tick(1);
		channel_power_on_command <= 4'h0;
		tick(3);
		check("dual_repower", {4'h0, ch_en}, 8'h0c);
		at_limit_pin <= 4'h8;
		tick(1200);
		rd_chk(8'h08, 8'hf0, 8'h00, "limit_early");
		tick(100);
		rd_chk(8'h08, 8'hf0, 8'h80, "limit_hit");
		at_limit_pin <= 4'h0;
		temp_high_pin <= 1'b1;
		tick(6);
		check("therm_off", {4'h0, ch_en}, 8'h00);
		check("therm_block", {7'h00, thermal_block}, 8'h01);
		rd_chk(8'h0a, 8'h80, 8'h80, "therm_flag");
		temp_high_pin <= 1'b0;
		temp_below_low_pin <= 1'b1;
		tick(5);
		check("therm_release", {7'h00, thermal_block}, 8'h00);
		channel_power_on_command <= 4'h4;
		tick(1);
		channel_power_on_command <= 4'h0;
		tick(3);
		check("therm_restart", {4'h0, ch_en}, 8'h04);
		rd_chk(8'h0a, 8'h02, 8'h00, "code_idle");
		shutdown_code_disable <= 4'h4;
		tick(1);
		shutdown_code_disable <= 4'h0;
		tick(3);
		rd_chk(8'h0a, 8'h02, 8'h02, "code_sd");
		rst(1'b0);
		auto_mode <= 1'b1;
		class_det_error <= 4'h1;
		tick(1);
		auto_mode <= 1'b0;
		class_det_error <= 4'h2;
		tick(1);
		class_det_error <= 4'h0;
		tick(2);
		rd_chk(8'h08, 8'hff, 8'h02, "auto_start");
		check("start_pend", {7'h00, start_event_pending}, 8'h01);
		rd_chk(8'h09, 8'hff, 8'h02, "start_clear");
		check("start_pend_clr", {7'h00, start_event_pending}, 8'h00);
		print_verdict();
	end
endmodule : tb

`default_nettype wire
